// File: pin_io_params.svh
`ifndef PIN_IO_PARAMS_SVH
`define PIN_IO_PARAMS_SVH

// Register byte offsets
`define OFF_IO_CTL_CH3_A 8'h00
`define OFF_IO_CTL_CH3_C 8'h04
`define OFF_IO_CTL_CH4 8'h08
`define OFF_IO_CTL_CH5 8'h0c
`define OFF_MODE_CH3 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_MASK 8'h18
`define OFF_GR_A_CH3 8'h20
`define OFF_GR_C_CH3 8'h24
`define OFF_GR_A_CH4 8'h28
`define OFF_GR_A_CH5 8'h2c

// Field positions inside an I/O control register, and the buffer-enable bit of the channel 3 mode register
`define FLD_KIND 3
`define FLD_LVL 2
`define FLD_ACT_MSB 1
`define FLD_ACT_LSB 0
`define BUF_A_EN_BIT 0

// Reset values
`define RST_IO_CTL 8'h00
`define RST_MODE_CH3 8'h00
`define RST_IRQ 4'h0

// Channel slots
`define SLOT_A3 0
`define SLOT_C3 1
`define SLOT_A4 2
`define SLOT_A5 3
`define NUM_SLOTS 4

`endif

// File: pin_io_pkg.sv
package pin_io_pkg;

	// Action taken on the pin at compare match
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOGGLE = 2'h3
	} pin_act_t;

	// Decoded meaning of one four-bit I/O mode field
	typedef struct packed {
		logic out_en;
		logic init_lvl;
		pin_act_t act;
		logic cap_rise;
		logic cap_fall;
		logic cascade;
	} io_mode_t;

endpackage : pin_io_pkg

// File: timer_pin_io_mode_select.sv
// The strobed register port and the address map are this design's own decisions.
`include "pin_io_params.svh"

module timer_pin_io_mode_select
	import pin_io_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	output logic irq,
	input wire logic [CNT_W-1:0] counter_ch3,
	input wire logic [CNT_W-1:0] counter_ch4,
	input wire logic [CNT_W-1:0] counter_ch5,
	input wire logic cmp_match_a_ch3,
	input wire logic cmp_match_c_ch3,
	input wire logic cmp_match_a_ch4,
	input wire logic cmp_match_a_ch5,
	input wire logic counter_ch4_up,
	input wire logic counter_ch4_down,
	input wire logic pin_a_ch3_in,
	output logic pin_a_ch3_out,
	output logic pin_a_ch3_oe,
	input wire logic pin_c_ch3_in,
	output logic pin_c_ch3_out,
	output logic pin_c_ch3_oe,
	input wire logic pin_a_ch4_in,
	output logic pin_a_ch4_out,
	output logic pin_a_ch4_oe,
	input wire logic pin_a_ch5_in,
	output logic pin_a_ch5_out,
	output logic pin_a_ch5_oe
);

	localparam int NS = `NUM_SLOTS;

	// Slot order used by every per-slot vector below:
	// slot 0 is channel 3 register A, slot 1 channel 3 register C,
	// slot 2 channel 4 register A, slot 3 channel 5 register A.
	// Interrupt status and mask bits follow the same order,
	// so software sees one bit per general register.
	// Only slot 1 can be taken out of service by buffer mode,
	// and only slot 3 lacks a cascaded capture source.
	// The four mode fields live in their own byte registers;
	// bits 7:4 of each are stored and read back but decode nothing.
	// Captured counts are read-only and sit in the low bits of a word.
	// Writes to unmapped or read-only addresses are dropped silently.
	// Reads of unmapped addresses return zero.

	// Decode order matters: the buffer block is tested first,
	// then the output/input choice, then the cascade, then edges.
	// Output compare keeps bit 2 as the initial level and bits 1:0
	// as the match action; action 00 leaves the pin undriven.
	// Input capture with bit 2 set becomes the cascaded source only
	// where the slot has one; elsewhere bit 2 is a don't-care.
	// Rising capture is taken for action 00 and both-edge codes,
	// falling capture for action 01 and both-edge codes.
	// The decode is pure logic so that a field write changes the
	// pin enable one clock later and capture selection at once.
	// Turns a mode field into pin and capture controls
	function automatic io_mode_t decode_mode(
		input logic [3:0] fld,
		input logic casc_ok,
		input logic blocked
	);
		io_mode_t m;
		m = '0;
		if (!blocked) begin
			if (!fld[`FLD_KIND]) begin
				m.out_en = (fld[`FLD_ACT_MSB:`FLD_ACT_LSB] != 2'h0);
				m.init_lvl = fld[`FLD_LVL];
				m.act = pin_act_t'(fld[`FLD_ACT_MSB:`FLD_ACT_LSB]);
			end else if (casc_ok && fld[`FLD_LVL]) begin
				m.cascade = 1'b1;
			end else begin
				// Bit 2 never reaches here on channels 3 and 4
				m.cap_rise = fld[`FLD_ACT_MSB] | ~fld[`FLD_ACT_LSB];
				m.cap_fall = fld[`FLD_ACT_MSB] | fld[`FLD_ACT_LSB];
			end
		end
		return m;
	endfunction : decode_mode

	// Field registers, buffer mode, interrupt state, captured values
	logic [7:0] io_ctl_ff [NS];
	logic [7:0] mode_reg_ch3_ff;
	logic [NS-1:0] irq_status_ff;
	logic [NS-1:0] irq_mask_ff;
	logic [CNT_W-1:0] gr_ff [NS];
	logic [NS-1:0] sync1_ff;
	logic [NS-1:0] sync2_ff;
	logic [NS-1:0] pin_prev_ff;
	logic [NS-1:0] pin_lvl_ff;
	logic [NS-1:0] pin_oe_ff;
	logic [31:0] rdata_ff;
	logic irq_ff;

	// Per-slot views of the ports
	logic [NS-1:0] pin_in_w;
	logic [NS-1:0] cmp_match_w;
	logic [CNT_W-1:0] cnt_w [NS];
	logic [7:0] fld_off_w [NS];
	logic [7:0] gr_off_w [NS];

	assign pin_in_w = {pin_a_ch5_in, pin_a_ch4_in, pin_c_ch3_in, pin_a_ch3_in};
	assign cmp_match_w = {cmp_match_a_ch5, cmp_match_a_ch4, cmp_match_c_ch3,
		cmp_match_a_ch3};
	assign cnt_w[`SLOT_A3] = counter_ch3;
	assign cnt_w[`SLOT_C3] = counter_ch3;
	assign cnt_w[`SLOT_A4] = counter_ch4;
	assign cnt_w[`SLOT_A5] = counter_ch5;
	assign fld_off_w[`SLOT_A3] = `OFF_IO_CTL_CH3_A;
	assign fld_off_w[`SLOT_C3] = `OFF_IO_CTL_CH3_C;
	assign fld_off_w[`SLOT_A4] = `OFF_IO_CTL_CH4;
	assign fld_off_w[`SLOT_A5] = `OFF_IO_CTL_CH5;
	assign gr_off_w[`SLOT_A3] = `OFF_GR_A_CH3;
	assign gr_off_w[`SLOT_C3] = `OFF_GR_C_CH3;
	assign gr_off_w[`SLOT_A4] = `OFF_GR_A_CH4;
	assign gr_off_w[`SLOT_A5] = `OFF_GR_A_CH5;

	// Buffer mode takes the C field out of service
	logic buf_a_en_w;
	assign buf_a_en_w = mode_reg_ch3_ff[`BUF_A_EN_BIT];

	// Pin edges from the synchronised levels
	logic [NS-1:0] rise_w;
	logic [NS-1:0] fall_w;
	assign rise_w = sync2_ff & ~pin_prev_ff;
	assign fall_w = ~sync2_ff & pin_prev_ff;

	// Compare events need an active output code; capture events need
	// an input code and a matching edge or cascade pulse.
	// Both kinds raise the same status bit of their slot.
	// The C slot produces neither while buffer mode holds it.
	// Per-slot decode and event generation
	io_mode_t mode_w [NS];
	logic [NS-1:0] wr_fld_w;
	logic [NS-1:0] cmp_evt_w;
	logic [NS-1:0] cap_evt_w;
	logic [NS-1:0] casc_src_w;
	logic [NS-1:0] new_out_w;
	logic [NS-1:0] nxt_pin_lvl;

	// Cascade sources are plain same-clock pulses.
	// Channel 3 counts either direction of channel 4 as a capture.
	// Channel 4 register A follows any compare or capture event of
	// channel 3 register A, taken in the same clock as that event.
	// A compare event counts only while that register's field holds an active output code.
	// Channel 5 has no cascade, so its source is tied low.
	// Cascade sources: channel 4 counting for channel 3, A3 events for A4
	assign casc_src_w[`SLOT_A3] = counter_ch4_up | counter_ch4_down;
	assign casc_src_w[`SLOT_C3] = counter_ch4_up | counter_ch4_down;
	assign casc_src_w[`SLOT_A4] = cmp_evt_w[`SLOT_A3] | cap_evt_w[`SLOT_A3];
	assign casc_src_w[`SLOT_A5] = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_slot
			localparam logic CASC_OK = (gi != `SLOT_A5);
			localparam logic CAN_BLOCK = (gi == `SLOT_C3);

			assign mode_w[gi] = decode_mode(io_ctl_ff[gi][3:0], CASC_OK,
				CAN_BLOCK && buf_a_en_w);
			assign wr_fld_w[gi] = wr_en && (addr == fld_off_w[gi]);
			// A write of an active output compare code shows its level at once
			assign new_out_w[gi] = wr_fld_w[gi] && !wdata[`FLD_KIND] &&
				(wdata[`FLD_ACT_MSB:`FLD_ACT_LSB] != 2'h0) &&
				!(CAN_BLOCK && buf_a_en_w);
			assign cmp_evt_w[gi] = cmp_match_w[gi] && mode_w[gi].out_en;
			assign cap_evt_w[gi] = (mode_w[gi].cap_rise && rise_w[gi]) ||
				(mode_w[gi].cap_fall && fall_w[gi]) ||
				(mode_w[gi].cascade && casc_src_w[gi]);

			// Pin level at compare match, after a fresh initial level
			always_comb begin
				nxt_pin_lvl[gi] = pin_lvl_ff[gi];
				if (new_out_w[gi]) begin
					nxt_pin_lvl[gi] = wdata[`FLD_LVL];
				end else if (cmp_evt_w[gi]) begin
					unique case (mode_w[gi].act)
						ACT_LOW: nxt_pin_lvl[gi] = 1'b0;
						ACT_HIGH: nxt_pin_lvl[gi] = 1'b1;
						ACT_TOGGLE: nxt_pin_lvl[gi] = ~pin_lvl_ff[gi];
						ACT_NONE: nxt_pin_lvl[gi] = pin_lvl_ff[gi];
					endcase
				end
			end

			// A write of an active output compare code and a compare match in the same clock:
			// the write wins and the new initial level is shown.
			// The captured count is held until the next capture event.
			// Field register, pin state and captured count
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					io_ctl_ff[gi] <= `RST_IO_CTL;
					pin_lvl_ff[gi] <= 1'b0;
					pin_oe_ff[gi] <= 1'b0;
					gr_ff[gi] <= '0;
				end else begin
					if (wr_fld_w[gi]) begin
						io_ctl_ff[gi] <= wdata;
					end
					pin_lvl_ff[gi] <= nxt_pin_lvl[gi];
					pin_oe_ff[gi] <= mode_w[gi].out_en;
					if (cap_evt_w[gi]) begin
						gr_ff[gi] <= cnt_w[gi];
					end
				end
			end
		end
	endgenerate

	// The pin inputs come from outside the clock domain.
	// Only the second stage feeds logic, so a metastable first stage
	// never reaches the edge detector or the capture enables.
	// The edge stage adds one more clock, so a capture lands three
	// clocks after the pin moves; a pulse must last one clock.
	// All stages reset low, matching the idle level of an undriven
	// pin, so no false edge follows reset.
	// Output-mode pins still pass through here, but their edges are
	// ignored because no capture mode is active for them.
	// Two-stage synchronisers, then a stage for edge detection
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			pin_prev_ff <= '0;
		end else begin
			sync1_ff <= pin_in_w;
			sync2_ff <= sync1_ff;
			pin_prev_ff <= sync2_ff;
		end
	end

	// Each compare or capture event sets its sticky status bit.
	// Software clears a bit by writing a one to it; a write of zero
	// leaves it alone.
	// When an event and a clear land in the same clock, the event
	// wins, so no event is ever lost to a late clear.
	// The interrupt output is registered from the next status value,
	// so it rises one clock after the event and falls one clock
	// after the clear, and never glitches.
	// The buffer-enable bit of the mode register is the only bit
	// with a function here; the others are stored for software.
	// Register writes for mode and interrupt control
	logic wr_mode_w;
	logic wr_status_w;
	logic wr_mask_w;
	logic [NS-1:0] nxt_irq_status;
	assign wr_mode_w = wr_en && (addr == `OFF_MODE_CH3);
	assign wr_status_w = wr_en && (addr == `OFF_IRQ_STATUS);
	assign wr_mask_w = wr_en && (addr == `OFF_IRQ_MASK);
	// Write one to clear; a new event in the same cycle wins
	assign nxt_irq_status = (irq_status_ff &
		~(wr_status_w ? wdata[NS-1:0] : '0)) | cmp_evt_w | cap_evt_w;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_reg_ch3_ff <= `RST_MODE_CH3;
			irq_status_ff <= `RST_IRQ;
			irq_mask_ff <= `RST_IRQ;
			irq_ff <= 1'b0;
		end else begin
			if (wr_mode_w) begin
				mode_reg_ch3_ff <= wdata;
			end
			if (wr_mask_w) begin
				irq_mask_ff <= wdata[NS-1:0];
			end
			irq_status_ff <= nxt_irq_status;
			irq_ff <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	// The read path is a plain address decode of every register.
	// Later tests in the process take priority, but no two
	// registers share an address, so the order is only cosmetic.
	// The result is registered, and the register bus returns it in
	// the cycle after the read strobe and only then; at all other
	// times the read data is zero, which keeps stale values off the
	// bus and makes a missed strobe easy to spot.
	// A write and a read never come together, so no bypass of a
	// just-written value is needed.
	// Read multiplexer; unmapped addresses read zero
	logic [31:0] rd_mux_w;
	always_comb begin
		rd_mux_w = '0;
		for (int i = 0; i < NS; i++) begin
			if (addr == fld_off_w[i]) begin
				rd_mux_w = {24'h000000, io_ctl_ff[i]};
			end
			if (addr == gr_off_w[i]) begin
				rd_mux_w = 32'(gr_ff[i]);
			end
		end
		if (addr == `OFF_MODE_CH3) begin
			rd_mux_w = {24'h000000, mode_reg_ch3_ff};
		end
		if (addr == `OFF_IRQ_STATUS) begin
			rd_mux_w = 32'(irq_status_ff);
		end
		if (addr == `OFF_IRQ_MASK) begin
			rd_mux_w = 32'(irq_mask_ff);
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= rd_en ? rd_mux_w : '0;
		end
	end

	// Every output comes straight from a flip-flop.
	// The pin level and the output enable are separate so that the
	// pad logic can combine them; the level holds while the enable
	// is low, except for a new initial level set by a field write.
	// A disabled or input-mode pin keeps its last level inside,
	// which is harmless because the enable keeps it off the wire.
	// The enable follows a field write one clock after the level.
	// During reset both are low and the pin floats to its pull.
	assign rdata = rdata_ff;
	assign irq = irq_ff;
	assign pin_a_ch3_out = pin_lvl_ff[`SLOT_A3];
	assign pin_c_ch3_out = pin_lvl_ff[`SLOT_C3];
	assign pin_a_ch4_out = pin_lvl_ff[`SLOT_A4];
	assign pin_a_ch5_out = pin_lvl_ff[`SLOT_A5];
	assign pin_a_ch3_oe = pin_oe_ff[`SLOT_A3];
	assign pin_c_ch3_oe = pin_oe_ff[`SLOT_C3];
	assign pin_a_ch4_oe = pin_oe_ff[`SLOT_A4];
	assign pin_a_ch5_oe = pin_oe_ff[`SLOT_A5];

endmodule : timer_pin_io_mode_select

// File: timer_pin_io_mode_select_checker.sv
`include "pin_io_params.svh"

module pin_io_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic cmp_match_a_ch3,
	input wire logic pin_a_ch3_out,
	input wire logic pin_a_ch3_oe,
	input wire logic pin_c_ch3_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] fa3_ff;
	logic buf_ff;
	// Field write and a match that no write overrides
	wire logic wa3 = wr_en && addr == `OFF_IO_CTL_CH3_A;
	wire logic hit3 = cmp_match_a_ch3 && !wa3 && !fa3_ff[3];
	// Shadow copies of the A3 field and the buffer flag
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fa3_ff <= 4'h0;
			buf_ff <= 1'b0;
		end else begin
			if (wa3)
				fa3_ff <= wdata[3:0];
			if (wr_en && addr == `OFF_MODE_CH3)
				buf_ff <= wdata[0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	init_level_a:
		assert property (wa3 && !wdata[3] && wdata[1:0] != 2'h0
		|=> pin_a_ch3_out == $past(wdata[2])) else $error("init level");
	oe_off_a:
		assert property ((fa3_ff[3] || fa3_ff[1:0] == 2'h0)
		&& $stable(fa3_ff) |-> !pin_a_ch3_oe) else $error("oe on");
	oe_on_a:
		assert property (!fa3_ff[3] && fa3_ff[1:0] != 2'h0
		&& $stable(fa3_ff) |-> pin_a_ch3_oe) else $error("oe off");
	match_low_a:
		assert property (hit3 && fa3_ff[1:0] == 2'h1 |=> !pin_a_ch3_out)
		else $error("not low");
	match_high_a:
		assert property (hit3 && fa3_ff[1:0] == 2'h2 |=> pin_a_ch3_out)
		else $error("not high");
	match_toggle_a:
		assert property (hit3 && fa3_ff[1:0] == 2'h3
		|=> pin_a_ch3_out != $past(pin_a_ch3_out)) else $error("no toggle");
	level_hold_a:
		assert property (!fa3_ff[3] && !cmp_match_a_ch3 && !wa3
		|=> $stable(pin_a_ch3_out)) else $error("level moved");
	buffer_quiet_a:
		assert property (buf_ff && $stable(buf_ff) |-> !pin_c_ch3_oe)
		else $error("buffer drives");
	c_toggle: cover property (hit3 && fa3_ff[1:0] == 2'h3);
	c_init: cover property (wa3 && wdata[2]);
	c_buf: cover property (buf_ff);
endmodule : pin_io_checker

bind timer_pin_io_mode_select pin_io_checker chk (.clk(clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr_en(wr_en),
	.cmp_match_a_ch3(cmp_match_a_ch3), .pin_a_ch3_out(pin_a_ch3_out),
	.pin_a_ch3_oe(pin_a_ch3_oe), .pin_c_ch3_oe(pin_c_ch3_oe));

// File: pin_far_end.sv
module pin_far_end (
	input wire logic [3:0] ext_lvl,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe,
	output logic [3:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wire follows the device while it drives, else the outside source
	assign pin_lvl = (dev_oe & dev_out) | (~dev_oe & ext_lvl);
endmodule : pin_far_end

// File: tb_timer_pin_io_mode_select.sv
module tb_timer_pin_io_mode_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic lv = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [3:0] cm = 4'h0;
	logic [3:0] ext = 4'h0;
	logic [1:0] cnt4 = 2'h0;
	logic [15:0] c3 = 16'h0000;
	logic [15:0] c4 = 16'h0000;
	logic [15:0] c5 = 16'h0000;
	logic [7:0] cap [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
	logic [31:0] rdata;
	logic irq;
	wire logic [3:0] po;
	wire logic [3:0] oe;
	wire logic [3:0] pin;
	int n_errors = 0;
	int n_checks = 0;
	int i;
	always #5 clk = ~clk;
	timer_pin_io_mode_select #(.CNT_W(16)) dut (.clk(clk), .rst_b(rst_b),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .irq(irq), .counter_ch3(c3), .counter_ch4(c4),
		.counter_ch5(c5), .cmp_match_a_ch3(cm[0]), .cmp_match_c_ch3(cm[1]),
		.cmp_match_a_ch4(cm[2]), .cmp_match_a_ch5(cm[3]),
		.counter_ch4_up(cnt4[1]), .counter_ch4_down(cnt4[0]),
		.pin_a_ch3_in(pin[0]), .pin_a_ch3_out(po[0]), .pin_a_ch3_oe(oe[0]),
		.pin_c_ch3_in(pin[1]), .pin_c_ch3_out(po[1]), .pin_c_ch3_oe(oe[1]),
		.pin_a_ch4_in(pin[2]), .pin_a_ch4_out(po[2]), .pin_a_ch4_oe(oe[2]),
		.pin_a_ch5_in(pin[3]), .pin_a_ch5_out(po[3]), .pin_a_ch5_oe(oe[3]));
	pin_far_end far (.ext_lvl(ext), .dev_out(po), .dev_oe(oe), .pin_lvl(pin));
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	// One-cycle read, data checked in the following cycle
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rdc
	// One-cycle compare match pulse
	task automatic hit(input int k);
		@(posedge clk);
		cm[k] <= 1'b1;
		@(posedge clk);
		cm[k] <= 1'b0;
		#1;
	endtask : hit
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// Hang guard
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rdc(8'h00, 32'h0);
		chk(oe, 4'h0);
		// Output codes 1 to 7 on A3: level at write, then one match
		for (i = 1; i < 8; i++) begin
			wr(8'h00, 8'(i));
			#1;
			if (i[1:0] != 2'h0)
				lv = i[2];
			chk(po[0], lv);
			@(posedge clk);
			#1;
			chk(oe[0], i[1:0] != 2'h0);
			hit(0);
			if (i[1:0] != 2'h0)
				lv = i[1:0] == 2'h3 ? !lv : i[1];
			chk(po[0], lv);
		end
		// Edge choice on A5, counter held apart for each edge
		foreach (cap[j]) begin
			wr(8'h0c, cap[j]);
			c5 <= {cap[j], 8'h01};
			ext[3] <= 1'b1;
			repeat (6) @(posedge clk);
			c5 <= {cap[j], 8'h02};
			ext[3] <= 1'b0;
			repeat (6) @(posedge clk);
			rdc(8'h2c, {16'h0, cap[j], (|cap[j][1:0] ? 8'h02 : 8'h01)});
		end
		// Channel 3 driven by channel 4 count down, then up
		wr(8'h00, 8'h0c);
		wr(8'h04, 8'h0c);
		for (i = 0; i < 2; i++) begin
			c3 <= 16'(48 + i);
			cnt4 <= 2'(i + 1);
			@(posedge clk);
			cnt4 <= 2'h0;
			rdc(8'h20, 32'(48 + i));
			rdc(8'h24, 32'(48 + i));
		end
		// A4 follows an A3 match; only bit 0 unmasked
		wr(8'h14, 8'h0f);
		wr(8'h18, 8'h01);
		wr(8'h00, 8'h03);
		wr(8'h08, 8'h0c);
		c4 <= 16'h0abc;
		hit(0);
		rdc(8'h28, 32'h0abc);
		chk(irq, 1'b1);
		// Buffered C3 stays silent
		wr(8'h10, 8'h01);
		wr(8'h04, 8'h07);
		hit(1);
		chk(oe[1], 1'b0);
		rdc(8'h14, 32'h5);
		wr(8'h14, 8'h01);
		@(posedge clk);
		#1;
		chk(irq, 1'b0);
		rdc(8'h14, 32'h4);
		rdc(8'hfc, 32'h0);
		// Outputs of C3, A4 and A5 from their initial level and a match
		wr(8'h10, 8'h00);
		wr(8'h04, 8'h07);
		wr(8'h08, 8'h06);
		wr(8'h0c, 8'h05);
		#1;
		chk(po[3:1], 3'h7);
		@(posedge clk);
		#1;
		chk(oe[3:1], 3'h7);
		hit(1);
		chk(po[1], 1'b0);
		hit(2);
		chk(po[2], 1'b1);
		hit(3);
		chk(po[3], 1'b0);
		close_out();
	end
endmodule : tb_timer_pin_io_mode_select
